// ===== core/mps_pkg.sv
`default_nettype none
package mps_pkg;
  // wishbone word offsets (byte addresses)
  localparam logic [7:0] MPS_OFF_MODE   = 8'h00; // protection_mode_select
  localparam logic [7:0] MPS_OFF_LEVELS = 8'h04; // overcurrent_output_levels
  localparam logic [7:0] MPS_OFF_CTRL   = 8'h08; // software protect controls
  localparam logic [7:0] MPS_OFF_STAT   = 8'h0c; // protection state readback
  // mode register field positions
  localparam int MPS_B_CAPO   = 0;
  localparam int MPS_B_CAPC   = 1;
  localparam int MPS_B_SENSE  = 2;
  localparam int MPS_B_AHL    = 3;
  localparam int MPS_B_PSWPS  = 4;
  localparam int MPS_MODE_W   = 7;
  localparam int MPS_LVL_W    = 6;
  // control register field positions
  localparam int MPS_B_SWBIT  = 0;
  localparam int MPS_B_SWEN   = 1;
  localparam int MPS_B_HWREL  = 2;
  // reset values
  localparam logic [6:0] MPS_MODE_RST = 7'h00;
  localparam logic [5:0] MPS_LVL_RST  = 6'h00;
  localparam logic [2:0] MPS_CTRL_RST = 3'h0;

  // six gate-drive lines, bit order c_low..a_high as in the level register
  typedef struct packed {
    logic phase_c_low_gate;
    logic phase_c_high_gate;
    logic phase_b_low_gate;
    logic phase_b_high_gate;
    logic phase_a_low_gate;
    logic phase_a_high_gate;
  } mps_gates_t;

  // protection trigger sources
  typedef struct packed {
    logic current_sense_event;
    logic capture_compare_event;
    logic capture_overflow_event;
  } mps_events_t;

  // protection latch state, gray order idle -> pause -> fault -> drop
  typedef enum logic [1:0] {
    MPS_ST_IDLE  = 2'b00,
    MPS_ST_PAUSE = 2'b01,
    MPS_ST_FAULT = 2'b11,
    MPS_ST_DROP  = 2'b10
  } mps_state_t;
endpackage
`default_nettype wire

// ===== core/mps_protect.sv
// What this block does
// RQ1 - capture overflow mode bit selects pause mode
// RQ2 - software sets capture compare bit to pause
// RQ3 - phase c gates forced to level bits
// RQ4 - phase b gates forced to level bits
// RQ5 - phase a gates forced to level bits
// RQ6 - level register bits 7 and 6 read zero
// RQ7 - current sense bit: 0 fault, 1 pause
// RQ8 - software bit triggers in pause, releases always
// RQ9 - latched overcurrent released by enable 1-0-1 toggle
//
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module mps_protect (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  // protection inputs, asynchronous to clk_i
  input  wire logic               overcurrent_i,
  input  wire mps_pkg::mps_events_t events_i,
  // pwm gate demand and gated drive
  input  wire mps_pkg::mps_gates_t pwm_i,
  output mps_pkg::mps_gates_t     gates_o,
  output logic                    protect_active_o
);
  import mps_pkg::*;

  // every protection pin arrives from outside the clock domain;
  // two stages cost two cycles of reaction time but keep a metastable
  // level away from the state logic
  // two-stage synchronisers for pins
  logic [3:0] sync1_reg;                  // first stage, read by stage 2 only
  logic [3:0] sync2_reg;                  // safe copies
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end else begin
      sync1_reg <= {overcurrent_i, events_i};
      sync2_reg <= sync1_reg;
    end
  end
  wire logic oc_s   = sync2_reg[3];       // over-current comparator
  wire logic is_s   = sync2_reg[2];       // current sense
  wire logic cmp_s  = sync2_reg[1];       // capture compare
  wire logic ovf_s  = sync2_reg[0];       // capture overflow

  // registers
  logic [MPS_MODE_W-1:0] mode_reg;        // protection_mode_select
  logic [MPS_LVL_W-1:0]  lvl_reg;         // overcurrent_output_levels
  logic [2:0]            ctrl_reg;        // sw bit, sw enable, hw release
  logic                  ack_reg;
  logic [31:0]           rdat_reg;

  // bus decode
  wire logic req      = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire logic wr_lane0 = req & wb_we_i & wb_sel_i[0];
  wire logic hit_mode = wb_adr_i == MPS_OFF_MODE;
  wire logic hit_lvl  = wb_adr_i == MPS_OFF_LEVELS;
  wire logic hit_ctrl = wb_adr_i == MPS_OFF_CTRL;
  wire logic hit_stat = wb_adr_i == MPS_OFF_STAT;

  // protection state
  mps_state_t st_reg;
  mps_state_t st_next;
  logic       hwrel_d_reg;                // previous release enable value
  logic       swbit_d_reg;                // previous software bit value

  wire logic swen     = ctrl_reg[MPS_B_SWEN];
  wire logic swbit    = ctrl_reg[MPS_B_SWBIT];
  wire logic hwrel    = ctrl_reg[MPS_B_HWREL];
  // current sense in fault mode latches, in pause mode follows [RQ7]
  wire logic is_fault = is_s & ~mode_reg[MPS_B_SENSE];        // [RQ7]
  // capture sources only work in pause mode; 0 is undefined, treated off
  wire logic cap_pause = (cmp_s & mode_reg[MPS_B_CAPC])        // [RQ2]
                       | (ovf_s & mode_reg[MPS_B_CAPO]);       // [RQ1]
  wire logic pause_src = (is_s & mode_reg[MPS_B_SENSE]) | cap_pause
                       | (swbit & swen & mode_reg[MPS_B_PSWPS]); // [RQ8]
  // release edge: enable seen high, low, now high again
  logic       rel_low_seen_reg;
  wire logic  hw_release = st_reg == MPS_ST_FAULT & rel_low_seen_reg
                         & hwrel & ~hwrel_d_reg;               // [RQ9]
  // software release: enabled bit rising while latched [RQ8]
  wire logic  sw_release = st_reg == MPS_ST_FAULT & swen
                         & swbit & ~swbit_d_reg;
  wire logic  fault_src  = (oc_s & hwrel) | is_fault;

  // next state of the protection latch
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      MPS_ST_IDLE: begin
        if (fault_src) st_next = MPS_ST_FAULT;
        else if (pause_src) st_next = MPS_ST_PAUSE;
      end
      MPS_ST_PAUSE: begin
        if (fault_src) st_next = MPS_ST_FAULT;
        else if (!pause_src) st_next = MPS_ST_IDLE;
      end
      MPS_ST_FAULT: begin
        if (hw_release | sw_release) st_next = MPS_ST_DROP;
      end
      MPS_ST_DROP: begin
        // one cycle out of protection before re-arming
        st_next = MPS_ST_IDLE;
      end
      default: st_next = MPS_ST_IDLE;
    endcase
  end

  wire logic active = st_reg == MPS_ST_PAUSE | st_reg == MPS_ST_FAULT;

  // level readback, upper two bits zero [RQ6]
  wire logic [7:0] lvl_rd  = {2'b00, lvl_reg};                 // [RQ6]
  wire logic [31:0] rd_mux =
      hit_mode ? {24'h0, 1'b0, mode_reg} :
      hit_lvl  ? {24'h0, lvl_rd} :
      hit_ctrl ? {29'h0, ctrl_reg} :
      hit_stat ? {30'h0, st_reg} : 32'h0;

  // levels are read live from the register, so software may change the
  // forced pattern while protection holds; it shows one cycle later
  // limitation: pwm_i is trusted to be on this clock and is not synced
  // gate selection: forced level while protected [RQ3] [RQ4] [RQ5]
  wire mps_gates_t gates_next = active ? mps_gates_t'(lvl_reg) : pwm_i;

  // register writes, byte lane 0 only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg <= MPS_MODE_RST;
      lvl_reg  <= MPS_LVL_RST;
      ctrl_reg <= MPS_CTRL_RST;
    end else if (wr_lane0) begin
      if (hit_mode) mode_reg <= wb_dat_i[MPS_MODE_W-1:0];
      if (hit_lvl)  lvl_reg  <= wb_dat_i[MPS_LVL_W-1:0];
      if (hit_ctrl) ctrl_reg <= wb_dat_i[2:0];
    end
  end

  // data is zero outside the ack cycle so a shared read bus can be
  // or-ed without a select
  // bus answer, one wait cycle, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0;
    end else begin
      ack_reg  <= req;
      rdat_reg <= req ? rd_mux : 32'h0;
    end
  end

  // protection latch and edge history
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg           <= MPS_ST_IDLE;
      hwrel_d_reg      <= 1'b0;
      swbit_d_reg      <= 1'b0;
      rel_low_seen_reg <= 1'b0;
    end else begin
      st_reg      <= st_next;
      hwrel_d_reg <= hwrel;
      swbit_d_reg <= swbit;
      // low must be seen after latching, set wins over clear [RQ9]
      if (st_reg == MPS_ST_FAULT & ~hwrel) rel_low_seen_reg <= 1'b1;
      else if (st_reg != MPS_ST_FAULT) rel_low_seen_reg <= 1'b0;
    end
  end

  // registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gates_o          <= '0;
      protect_active_o <= 1'b0;
    end else begin
      gates_o          <= gates_next;                 // [RQ3] [RQ4] [RQ5]
      protect_active_o <= active;
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // assertions
  a_gate_force_level: assert property (@(posedge clk_i) disable iff (rst_i)
    active |=> gates_o == mps_gates_t'($past(lvl_reg))) // [RQ5]
    else $error("gates not forced to level");
  a_gate_pass_pwm: assert property (@(posedge clk_i) disable iff (rst_i)
    !active |=> gates_o == $past(pwm_i)) // [RQ4]
    else $error("pwm not passed");
  a_phase_c_force: assert property (@(posedge clk_i) disable iff (rst_i)
    active |=> gates_o.phase_c_low_gate == $past(lvl_reg[5])) // [RQ3]
    else $error("phase c low not forced");
  a_level_top_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_reg && $past(hit_lvl) |-> wb_dat_o[7:6] == 2'b00) // [RQ6]
    else $error("level top bits not zero");
  a_ovf_pause_go: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == MPS_ST_IDLE && ovf_s && mode_reg[MPS_B_CAPO] && !fault_src
    |=> st_reg == MPS_ST_PAUSE) // [RQ1]
    else $error("overflow did not pause");
  a_is_fault_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    is_s && !mode_reg[MPS_B_SENSE] && st_reg != MPS_ST_DROP
    && !hw_release && !sw_release
    |=> st_reg == MPS_ST_FAULT) // [RQ7]
    else $error("current sense fault not latched");
  a_fault_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == MPS_ST_FAULT && !hw_release && !sw_release
    |=> st_reg == MPS_ST_FAULT) // [RQ9]
    else $error("fault released without toggle");
  a_sw_release: assert property (@(posedge clk_i) disable iff (rst_i)
    sw_release |=> st_reg == MPS_ST_DROP ##1 st_reg != MPS_ST_FAULT) // [RQ8]
    else $error("software release failed");
  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  // per-phase forcing, one line each so a swapped bit shows
  a_phase_c_high: assert property (@(posedge clk_i) disable iff (rst_i)
    active |=> gates_o.phase_c_high_gate == $past(lvl_reg[4])) // [RQ3]
    else $error("phase c high not forced");
  a_phase_b_low: assert property (@(posedge clk_i) disable iff (rst_i)
    active |=> gates_o.phase_b_low_gate == $past(lvl_reg[3])) // [RQ4]
    else $error("phase b low not forced");
  a_phase_b_high: assert property (@(posedge clk_i) disable iff (rst_i)
    active |=> gates_o.phase_b_high_gate == $past(lvl_reg[2])) // [RQ4]
    else $error("phase b high not forced");
  a_phase_a_low: assert property (@(posedge clk_i) disable iff (rst_i)
    active |=> gates_o.phase_a_low_gate == $past(lvl_reg[1])) // [RQ5]
    else $error("phase a low not forced");
  a_phase_a_high: assert property (@(posedge clk_i) disable iff (rst_i)
    active |=> gates_o.phase_a_high_gate == $past(lvl_reg[0])) // [RQ5]
    else $error("phase a high not forced");

  // entry into pause for the compare, sense and software sources in pause mode
  a_cmp_pause_go: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == MPS_ST_IDLE && cmp_s && mode_reg[MPS_B_CAPC] && !fault_src
    |=> st_reg == MPS_ST_PAUSE) // [RQ2]
    else $error("compare did not pause");
  a_sense_pause_go: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == MPS_ST_IDLE && is_s && mode_reg[MPS_B_SENSE] && !fault_src
    |=> st_reg == MPS_ST_PAUSE) // [RQ7]
    else $error("current sense did not pause");
  a_sw_pause_go: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == MPS_ST_IDLE && swbit && swen && mode_reg[MPS_B_PSWPS]
    && !fault_src |=> st_reg == MPS_ST_PAUSE) // [RQ8]
    else $error("software bit did not pause");

  // leaving pause and the release cycle
  a_pause_ends: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == MPS_ST_PAUSE && !pause_src && !fault_src
    |=> st_reg == MPS_ST_IDLE) // [RQ8]
    else $error("pause not left");
  a_drop_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == MPS_ST_DROP |=> st_reg == MPS_ST_IDLE) // [RQ9]
    else $error("release cycle too long");

  // over-current latch and its toggle release
  a_oc_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    oc_s && hwrel && st_reg != MPS_ST_DROP && !hw_release && !sw_release
    |=> st_reg == MPS_ST_FAULT) // [RQ9]
    else $error("over-current not latched");
  a_hw_release: assert property (@(posedge clk_i) disable iff (rst_i)
    hw_release |=> st_reg == MPS_ST_DROP) // [RQ9]
    else $error("toggle release failed");

  // outputs and bus answer
  a_active_out: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> protect_active_o == $past(active))
    else $error("active output wrong");
  a_ack_after_req: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> wb_ack_o)
    else $error("request not acked");
  a_dat_zero_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero when idle");
endmodule
`default_nettype wire

// ===== testbench/tb_mps_protect.sv
`timescale 1ns/1ns
`default_nettype none
// one compare, counted; a mismatch is reported at once
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %0t got %h exp %h", $time, (g), (e)); end end
module tb_mps_protect;
  import mps_pkg::*;
  // clock, reset and bus master signals
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] wdat  = 32'h0;
  logic [31:0] rd;
  logic [31:0] dat_o;
  logic        ack;
  // protection stimulus and observed drive
  logic        oc    = 1'b0;
  mps_events_t ev    = '0;
  mps_gates_t  pwm   = '0;
  mps_gates_t  gts;
  logic        act;
  int          mismatches = 0;
  int          n_checks   = 0;

  // 4 ns period
  always #2 clk_i = ~clk_i;

  mps_protect uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .overcurrent_i(oc), .events_i(ev),
    .pwm_i(pwm), .gates_o(gts), .protect_active_o(act)
  );

  // verdict and end of run, shared with the watchdog
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // classic cycle; ack read as sampled at the edge, request held until then
  task bus(input logic [7:0] a, input logic w, input logic [3:0] s,
           input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; adr <= a; we <= w; sel <= s; wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    `CHK(ack, 1'b1)
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, 4'h1, d);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 4'hf, 32'h0);
    `CHK(rd, e)
  endtask

  // pin to gates_o takes 4 edges; one spare before looking
  task wt;
    repeat (5) @(posedge clk_i);
    #1;
  endtask

  task chk_out(input logic a, input logic [5:0] g);
    `CHK(act, a)
    `CHK(gts, g)
  endtask

  // watchdog: the sequence needs well under 1000 cycles
  initial begin
    #20000;
    mismatches++;
    finish_test;
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(MPS_OFF_MODE, 32'h0);
    rdc(MPS_OFF_LEVELS, 32'h0);
    rdc(8'h10, 32'h0);
    wr(MPS_OFF_LEVELS, 32'hff);
    rdc(MPS_OFF_LEVELS, 32'h3f);
    // lane 0 not selected, so the write must be dropped
    bus(MPS_OFF_LEVELS, 1'b1, 4'he, 32'h00);
    rdc(MPS_OFF_LEVELS, 32'h3f);
    wr(MPS_OFF_LEVELS, 32'h2a);
    @(posedge clk_i) pwm <= 6'h15;
    wt;
    chk_out(1'b0, 6'h15);
    $display("test registers done");
    // each event pause source: mode bit index equals event bit index
    for (int i = 0; i < 3; i++) begin
      wr(MPS_OFF_MODE, 32'h1 << i);
      @(posedge clk_i) ev <= 3'(1 << i);
      wt;
      chk_out(1'b1, 6'h2a);
      @(posedge clk_i) ev <= '0;
      wt;
      chk_out(1'b0, 6'h15);
    end
    $display("test pause sources done");
    // current sense in fault mode latches past the event
    wr(MPS_OFF_MODE, 32'h0);
    @(posedge clk_i) ev <= 3'h4;
    wt;
    @(posedge clk_i) ev <= '0;
    wt;
    chk_out(1'b1, 6'h2a);
    rdc(MPS_OFF_STAT, 32'h3);
    wr(MPS_OFF_CTRL, 32'h2);
    wt;
    chk_out(1'b1, 6'h2a);
    wr(MPS_OFF_CTRL, 32'h3);
    wt;
    chk_out(1'b0, 6'h15);
    $display("test fault release done");
    // software pause mode: bit both triggers and releases
    wr(MPS_OFF_CTRL, 32'h0);
    wr(MPS_OFF_MODE, 32'h10);
    rdc(MPS_OFF_MODE, 32'h10);
    wr(MPS_OFF_CTRL, 32'h3);
    wt;
    chk_out(1'b1, 6'h2a);
    wr(MPS_OFF_CTRL, 32'h2);
    wt;
    chk_out(1'b0, 6'h15);
    $display("test software pause done");
    // over-current: ignored while disabled, then latched until 1-0-1
    wr(MPS_OFF_MODE, 32'h0);
    wr(MPS_OFF_CTRL, 32'h0);
    @(posedge clk_i) oc <= 1'b1;
    wt;
    chk_out(1'b0, 6'h15);
    @(posedge clk_i) oc <= 1'b0;
    wr(MPS_OFF_CTRL, 32'h4);
    @(posedge clk_i) oc <= 1'b1;
    wt;
    @(posedge clk_i) oc <= 1'b0;
    wt;
    chk_out(1'b1, 6'h2a);
    wr(MPS_OFF_CTRL, 32'h0);
    wt;
    chk_out(1'b1, 6'h2a);
    wr(MPS_OFF_CTRL, 32'h4);
    wt;
    chk_out(1'b0, 6'h15);
    $display("test over-current done");
    finish_test;
  end
endmodule
`default_nettype wire
